// >>> common/dbgtp_pkg.sv
/*
 * Shared constants and types for the debug serial and trace port.
 * Assumes a single 125 MHz core clock with synchronous active-low reset.
 */
package dbgtp_pkg;

  localparam int unsigned STAT_W       = 4;
  localparam int unsigned DATA_W       = 4;
  localparam int unsigned SHIFT_W      = 8;
  localparam int unsigned FIFO_DEPTH   = 8;

  // Status codes: idle, reset exception processing (0xc, 0xd) and halted (0xf)
  localparam logic [3:0]  STAT_IDLE    = 4'h0;
  localparam logic [3:0]  STAT_RST_C   = 4'hc;
  localparam logic [3:0]  STAT_RST_D   = 4'hd;
  localparam logic [3:0]  STAT_HALT    = 4'hf;

  // Reset values of the pin registers
  localparam logic        SO_RST       = 1'b0;
  localparam logic [7:0]  SHIFT_RST    = 8'h00;

  typedef struct packed {
    logic [3:0] status;
    logic [3:0] ddata;
  } dbgtp_trace_s;

  typedef enum logic [1:0] {
    DBGTP_WAIT_START,
    DBGTP_RUN,
    DBGTP_SILENT
  } dbgtp_trc_e;

endpackage

// >>> logic/dbgtp_fifo.sv
/*
 * Parameterised valid/ready FIFO for trace words.
 * Assumes one clock, synchronous active-low reset.
 */
module dbgtp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             ready_q;
  wire  [AW:0]      cnt_d;
  wire              push;
  wire              pop;

  // Ready is registered from the next count so it leaves a flop
  assign in_ready_o  = ready_q;
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign cnt_d       = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
      ready_q <= 1'b1;
    end else begin
      if (push) wr_q <= AW'((wr_q + 1'b1) % DEPTH);
      if (pop)  rd_q <= AW'((rd_q + 1'b1) % DEPTH);
      cnt_q <= cnt_d;
      ready_q <= (cnt_d != (AW+1)'(DEPTH));
    end
  end
endmodule

// >>> logic/dbgtp_port.sv
/*
 * Debug serial port and real-time trace outputs of the processor.
 * Assumes the core supplies status and data each cycle on core_clk_i
 * and the debugger drives the serial clock and input asynchronously.
 */
// What this block does
// - Serial input is synchronised and taken once the clock is seen high.
// - Serial output is a register that changes after clock high is valid.
// - Trace clock is the core clock divided by two, rising mid-way through each word.
// - The disable bit freezes trace clock, status and data; triggers run.
// - Clearing the disable bit resumes toggling; the debugger resyncs.
// - After reset the trace clock idles until the first status 0xc, 0xd or 0xf.
// - The 4-bit status code is timed to the core clock, not to bus cycles.
// - The all-status flag is the AND of the four status bits.
// - The 4-bit debug data output shows captured data and breakpoint status.
// - A new serial clock level counts only when seen the same on two edges.
// - Each validated serial clock rise without a load samples the input, updates output.
// - A halted processor shows 0xf on status and debug data.
module dbgtp_port (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  // Serial debug link pins
  input  wire logic       dev_serial_clock_i,
  input  wire logic       dev_serial_in_i,
  output logic            dev_serial_out_o,
  // Debug module side of the serial link
  output logic [7:0]      rx_byte_o,
  output logic            rx_byte_valid_o,
  input  wire logic [7:0] tx_byte_i,
  input  wire logic       tx_load_i,
  // Core trace sources
  input  wire logic [3:0] core_status_i,
  input  wire logic [3:0] core_ddata_i,
  input  wire logic       core_halted_i,
  input  wire logic       trace_valid_i,
  output logic            trace_ready_o,
  input  wire logic       trace_clock_disable_i,
  input  wire logic       trigger_i,
  // Trace pins
  output logic            trace_clock_out_o,
  output logic [3:0]      core_status_code_o,
  output logic [3:0]      debug_data_nibble_o,
  output logic            all_status_ones_flag_o,
  output logic            trigger_o
);

  // Pin synchronisers
  logic       sclk_m_q, sclk_s_q, sclk_v_q, sclk_prev_q;
  logic       sin_m_q, sin_s_q;
  logic [7:0] rx_q, tx_q;
  logic [2:0] bit_q;
  logic       so_q, rxv_q;
  wire        sclk_rise;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sclk_m_q <= 1'b0;
      sclk_s_q <= 1'b0;
      sin_m_q  <= 1'b0;
      sin_s_q  <= 1'b0;
    end else begin
      sclk_m_q <= dev_serial_clock_i;
      sclk_s_q <= sclk_m_q;
      sin_m_q  <= dev_serial_in_i;
      sin_s_q  <= sin_m_q;
    end
  end

  // A level is accepted only after two equal consecutive samples
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sclk_prev_q <= 1'b0;
      sclk_v_q    <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s_q;
      if (sclk_s_q == sclk_prev_q) sclk_v_q <= sclk_s_q;
    end
  end

  assign sclk_rise = (sclk_s_q == sclk_prev_q) && sclk_s_q && !sclk_v_q;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rx_q  <= dbgtp_pkg::SHIFT_RST;
      tx_q  <= dbgtp_pkg::SHIFT_RST;
      bit_q <= 3'h0;
      so_q  <= dbgtp_pkg::SO_RST;
      rxv_q <= 1'b0;
    end else begin
      rxv_q <= 1'b0;
      if (tx_load_i) begin
        tx_q  <= tx_tail(tx_byte_i);
        so_q  <= tx_byte_i[7];
        bit_q <= 3'h0;
      end else if (sclk_rise) begin
        rx_q  <= {rx_q[6:0], sin_s_q};
        so_q  <= tx_q[7];
        tx_q  <= tx_tail(tx_q);
        bit_q <= bit_q + 3'h1;
        rxv_q <= (bit_q == 3'h7);
      end
    end
  end

  function automatic logic [7:0] tx_tail(input logic [7:0] v);
    tx_tail = {v[6:0], 1'b0};
  endfunction

  assign dev_serial_out_o = so_q;
  assign rx_byte_o        = rx_q;
  assign rx_byte_valid_o  = rxv_q;

  // Trace path: words are buffered so a short stall in the pin stage
  // does not drop status; ready back-pressures the core.
  dbgtp_pkg::dbgtp_trace_s in_w, out_w;
  logic                    out_valid;
  wire                     out_ready;
  wire                     start_code;

  assign in_w.status = core_halted_i ? dbgtp_pkg::STAT_HALT
                                     : core_status_i;
  assign in_w.ddata  = core_halted_i ? dbgtp_pkg::STAT_HALT
                                     : core_ddata_i;

  dbgtp_fifo #(
    .WIDTH (dbgtp_pkg::STAT_W + dbgtp_pkg::DATA_W),
    .DEPTH (dbgtp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (core_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (trace_valid_i),
    .in_ready_o  (trace_ready_o),
    .in_data_i   (in_w),
    .out_valid_o (out_valid),
    .out_ready_i (out_ready),
    .out_data_o  (out_w)
  );

  dbgtp_pkg::dbgtp_trc_e st_q;
  logic       phase_q, tclk_q, allp_q, trig_q;
  logic [3:0] stat_q, dd_q;

  // Before start only non-start words are dropped, so the start code
  // itself reaches the pins; while silent the buffer stalls the core.
  assign out_ready  = (st_q == dbgtp_pkg::DBGTP_WAIT_START) ? !start_code
                    : (st_q == dbgtp_pkg::DBGTP_RUN)
                      && !trace_clock_disable_i && !phase_q;
  assign start_code = (out_w.status == dbgtp_pkg::STAT_RST_C)
                   || (out_w.status == dbgtp_pkg::STAT_RST_D)
                   || (out_w.status == dbgtp_pkg::STAT_HALT);

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_q <= dbgtp_pkg::DBGTP_WAIT_START;
    end else begin
      case (st_q)
        dbgtp_pkg::DBGTP_WAIT_START:
          if (out_valid && start_code) st_q <= dbgtp_pkg::DBGTP_RUN;
        dbgtp_pkg::DBGTP_RUN:
          if (trace_clock_disable_i) st_q <= dbgtp_pkg::DBGTP_SILENT;
        dbgtp_pkg::DBGTP_SILENT:
          if (!trace_clock_disable_i) st_q <= dbgtp_pkg::DBGTP_RUN;
        default: st_q <= dbgtp_pkg::DBGTP_WAIT_START;
      endcase
    end
  end

  // Outputs change at phase 0, clock rises at phase 1: mid-interval edge
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      phase_q <= 1'b0;
      tclk_q  <= 1'b0;
      stat_q  <= dbgtp_pkg::STAT_IDLE;
      dd_q    <= dbgtp_pkg::STAT_IDLE;
      allp_q  <= 1'b0;
    end else if (st_q == dbgtp_pkg::DBGTP_RUN && !trace_clock_disable_i) begin
      phase_q <= !phase_q;
      tclk_q  <= phase_q;
      if (!phase_q && out_valid) begin
        stat_q <= out_w.status;
        dd_q   <= out_w.ddata;
        allp_q <= &out_w.status;
      end
    end else begin
      phase_q <= 1'b0;
      tclk_q  <= 1'b0;
    end
  end

  // Triggers keep working while the trace pins are silent
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) trig_q <= 1'b0;
    else          trig_q <= trigger_i;
  end

  assign trace_clock_out_o      = tclk_q;
  assign core_status_code_o     = stat_q;
  assign debug_data_nibble_o    = dd_q;
  assign all_status_ones_flag_o = allp_q;
  assign trigger_o              = trig_q;

  property p_allp;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    allp_q == (&stat_q);
  endproperty
  a_allp: assert property (p_allp)
    else $error("all-status flag wrong");
  property p_silent;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    st_q == dbgtp_pkg::DBGTP_SILENT |=> $stable(stat_q) && !tclk_q;
  endproperty
  a_silent: assert property (p_silent)
    else $error("trace toggled while silenced");
  property p_idle;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    st_q == dbgtp_pkg::DBGTP_WAIT_START |-> !tclk_q;
  endproperty
  a_idle: assert property (p_idle)
    else $error("trace clock ran before start");
  property p_mid;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(tclk_q) |-> $stable(stat_q) && $stable(dd_q);
  endproperty
  a_mid: assert property (p_mid)
    else $error("trace edge not mid interval");
  property p_filt;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(sclk_v_q) |-> $past(sclk_s_q) && $past(sclk_prev_q);
  endproperty
  a_filt: assert property (p_filt)
    else $error("serial clock accepted early");
  property p_rx;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    sclk_rise && !tx_load_i |=> rx_q[0] == $past(sin_s_q);
  endproperty
  a_rx: assert property (p_rx)
    else $error("serial bit not taken");
  property p_so;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $changed(so_q) |-> $past(sclk_rise) || $past(tx_load_i);
  endproperty
  a_so: assert property (p_so)
    else $error("serial out changed without clock");
  property p_halt;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    core_halted_i |-> in_w.status == dbgtp_pkg::STAT_HALT;
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt not shown as 0xf");
endmodule

// >>> test/dbgtp_debugger.sv
/*
 * Debugger model: serial link master and trace sampler.
 * Assumes the port's pins; its link clock stands low outside frames.
 */
module dbgtp_debugger (
  // Serial link
  output logic            dev_serial_clock_o,
  output logic            dev_serial_in_o,
  input  wire logic       dev_serial_out_i,
  // Trace pins
  input  wire logic       trace_clock_out_i,
  input  wire logic [3:0] core_status_code_i,
  input  wire logic [3:0] debug_data_nibble_i,
  input  wire logic       all_status_ones_flag_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] smp_q[$];
  logic [7:0] so_byte;
  initial begin
    dev_serial_clock_o = 1'b0;
    dev_serial_in_o    = 1'b0;
  end
  // Sample mid-way through each word
  always @(posedge trace_clock_out_i) begin
    smp_q.push_back({core_status_code_i, debug_data_nibble_i,
                     all_status_ones_flag_i});
  end
  // Output bit is read late in the low phase, well after it settled
  task automatic xfer(input logic [7:0] tx);
    for (int i = 7; i >= 0; i--) begin
      dev_serial_in_o = tx[i];
      #40 so_byte = {so_byte[6:0], dev_serial_out_i};
      dev_serial_clock_o = 1'b1;
      #40 dev_serial_clock_o = 1'b0;
    end
    // Released line shows no stale value
    dev_serial_in_o = ~tx[0];
  endtask
endmodule

// >>> test/dbgtp_port_tb_top.sv
/*
 * Self-checking bench for the debug serial and trace port.
 * Assumes dbgtp_debugger on the far side and a 125 MHz core clock.
 */
module dbgtp_port_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, rst_n, sclk, sdin, sdout, rx_v, tx_ld, halt;
  logic       tval, trdy, tdis, trg_i, trg_o, tclk, flag;
  logic [7:0] rx_b, tx_b, rx_last;
  logic [3:0] st_i, dd_i, st_o, dd_o;
  int         num_errors = 0;
  int         num_checks = 0;
  int         cyc = 0;
  int         rx_cnt = 0;
  int         ts_cnt = 0;
  int         n;
  // Rows: status, data, expected all-ones flag
  logic [8:0] rows [8] = '{9'h182, 9'h0a4, 9'h1e7, 9'h0fc,
                           9'h1a0, 9'h172, 9'h01e, 9'h1c8};

  dbgtp_port dut (
    .core_clk_i(clk), .rst_n_i(rst_n), .dev_serial_clock_i(sclk),
    .dev_serial_in_i(sdin), .dev_serial_out_o(sdout), .rx_byte_o(rx_b),
    .rx_byte_valid_o(rx_v), .tx_byte_i(tx_b), .tx_load_i(tx_ld),
    .core_status_i(st_i), .core_ddata_i(dd_i), .core_halted_i(halt),
    .trace_valid_i(tval), .trace_ready_o(trdy),
    .trace_clock_disable_i(tdis), .trigger_i(trg_i),
    .trace_clock_out_o(tclk), .core_status_code_o(st_o),
    .debug_data_nibble_o(dd_o), .all_status_ones_flag_o(flag),
    .trigger_o(trg_o));

  dbgtp_debugger dbg (
    .dev_serial_clock_o(sclk), .dev_serial_in_o(sdin),
    .dev_serial_out_i(sdout), .trace_clock_out_i(tclk),
    .core_status_code_i(st_o), .debug_data_nibble_i(dd_o),
    .all_status_ones_flag_i(flag));

  task automatic chk(string nm, logic [8:0] exp, logic [8:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Offer one word; the request stands until ready is seen high
  task automatic push(logic [7:0] w);
    {st_i, dd_i} <= w;
    tval <= 1'b1;
    @(negedge clk);
    while (trdy !== 1'b1) @(negedge clk);
    @(posedge clk);
  endtask

  task automatic wait_ts(int k);
    for (int i = 0; i < 200 && ts_cnt < k; i++) @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rx_v === 1'b1) begin
      rx_cnt  <= rx_cnt + 1;
      rx_last <= rx_b;
    end
    if (cyc == 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  always @(posedge tclk) ts_cnt <= ts_cnt + 1;

  initial begin
    {rst_n, tx_ld, halt, tval, tdis, trg_i} = '0;
    {tx_b, st_i, dd_i} = '0;
    repeat (10) @(posedge clk);
    chk("reset pins", 9'h001, {dd_o, tclk, flag, trg_o, sdout, trdy});
    chk("reset status", 9'h000, 9'(st_o));
    rst_n <= 1'b1;
    repeat (20) @(posedge clk);
    chk("idle trace clock", 9'h000, 9'(ts_cnt));
    // Silenced: FIFO fills until it refuses
    tdis <= 1'b1;
    for (n = 0; n < 9; n++) begin
      {st_i, dd_i} <= rows[n % 8][8:1];
      tval <= 1'b1;
      @(negedge clk);
      if (trdy !== 1'b1) break;
      @(posedge clk);
    end
    @(posedge clk);
    tval <= 1'b0;
    trg_i <= 1'b1;
    chk("fill count", 9'h008, 9'(n));
    chk("held pins", 9'h000, {st_o, dd_o, flag});
    @(posedge clk);
    trg_i <= 1'b0;
    @(negedge clk);
    chk("trigger", 9'h001, 9'(trg_o));
    chk("silent edges", 9'h000, 9'(ts_cnt));
    @(posedge clk);
    tdis <= 1'b0;
    wait_ts(8);
    for (int i = 0; i < 8; i++)
      chk("trace word", rows[i], dbg.smp_q.pop_front());
    tdis <= 1'b1;
    push(8'h3a);
    tval <= 1'b0;
    repeat (20) @(posedge clk);
    chk("silent count", 9'h008, 9'(ts_cnt));
    tdis <= 1'b0;
    wait_ts(9);
    chk("resumed word", 9'h074, dbg.smp_q.pop_front());
    halt <= 1'b1;
    push(8'h12);
    tval <= 1'b0;
    // The free-running trace clock keeps repeating the halt word 0xf
    wait_ts(11);
    chk("halt word", 9'h1ff, dbg.smp_q.pop_back());
    halt <= 1'b0;
    // Serial bytes both ways, back to back
    for (int i = 0; i < 2; i++) begin
      tx_b <= i ? 8'h81 : 8'ha5;
      tx_ld <= 1'b1;
      @(posedge clk);
      tx_ld <= 1'b0;
      #3 dbg.xfer(i ? 8'h7e : 8'h3c);
      repeat (10) @(posedge clk);
      chk("rx byte", i ? 9'h07e : 9'h03c, 9'(rx_last));
      chk("rx pulses", 9'(i + 1), 9'(rx_cnt));
      chk("out byte", i ? 9'h081 : 9'h0a5, 9'(dbg.so_byte));
    end
    end_of_test();
  end
endmodule
